/* rtl/cosp_pkg.sv */
// Constants and types shared by the clock output stop and power down block
package cosp_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLOCK_MHZ       = 10;
   localparam int LOCK_TIME_US    = 1000;
   localparam int LOCK_CYCLES     = LOCK_TIME_US * CLOCK_MHZ;
   localparam int PD_EDGES        = 2;
   localparam int CPU_HALF_CYCLES = 1;
   localparam int SE_HALF_CYCLES  = 2;

   // ------------------------------------------------------------------
   // Drive strength and identification register
   // ------------------------------------------------------------------
   localparam int          DRV_MSB       = 7;
   localparam int          DRV_LSB       = 5;
   localparam logic [2:0]  DRV_RESET     = 3'h5;
   localparam logic [2:0]  SLEW_NORMAL   = 3'h5;
   localparam logic [2:0]  SLEW_WIRELESS = 3'h7;
   localparam int          NUM_CPU       = 2;
   localparam int          NUM_SE        = 3;
   localparam int          SE_USB        = 0;
   localparam int          SE_V27_PLAIN  = 1;
   localparam int          SE_V27_SPREAD = 2;

   typedef struct packed {
      logic [2:0] drive;
      logic [4:0] ident;
   } cosp_drive_id_t;

   // ------------------------------------------------------------------
   // Spread select decode
   // ------------------------------------------------------------------
   typedef struct packed {
      logic       valid;
      logic       center;
      logic [7:0] depth_x100;
   } cosp_spread_t;

   // ------------------------------------------------------------------
   // Power sequence states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      PWR_WAIT_GOOD = 3'h0,
      PWR_WAKE      = 3'h1,
      PWR_RUN       = 3'h3,
      PWR_STOP_OUT  = 3'h2,
      PWR_OFF       = 3'h6
   } cosp_pwr_t;

endpackage : cosp_pkg

/* rtl/cosp_clock_gate.sv */
// Output gating, power down and CPU stop control of the clock generator
//
// What this block does
// [RULE_01] Shared pin is power good first, then active-low power-down request.
// [RULE_02] Power-down pin is synchronised internally; release starts power-up.
// [RULE_03] Outputs go low and hold before oscillator and VCOs switch off.
// [RULE_04] Act on request after two CPU rising edges; single-ended stop at fall.
// [RULE_05] Controller pulls request low within 10 us of power good if wanted.
// [RULE_06] Powered down: single-ended low or high-z with strap; differential legs low.
// [RULE_07] Stable clocks less than 1.8 ms after release or supply ramp.
// [RULE_08] After release, differential outputs driven high within 300 us.
// [RULE_09] After lock each output starts within a few of its own cycles.
// [RULE_10] CPU halt input stops only CPU outputs; others keep running.
// [RULE_11] Halt registered on two complement edges; stop within two to six periods.
// [RULE_12] Stopped CPU pair rests true high, complement low.
// [RULE_13] Non-stoppable outputs run during halt; disabled outputs driven low.
// [RULE_14] CPU outputs resume in step, no short or stretched pulse.
// [RULE_15] Resume within two CPU cycles of halt release.
// [RULE_16] Four-bit spread select routes the 27 MHz pins; other codes unused.
// [RULE_17] Per-output bit: 0 free running, 1 stoppable.
// [RULE_18] Wireless mode sets single-ended slew default 111, else 101.
// [RULE_19] USB drive field resets to 101; five-bit identification reads back.
// [RULE_20] Power-down request overrides CPU halt and output enables.
`timescale 1ns/100ps

module cosp_clock_gate
   import cosp_pkg::*;
#(
   parameter int         LOCK_WAIT     = LOCK_CYCLES,
   parameter logic [4:0] PROGRAMMED_ID = 5'h00      // Arbitrary value
) (
   input  wire logic                clock,                    // 10 MHz
   input  wire logic                rst,                      // Async, high
   input  wire logic                power_good_pd_n,          // Shared pin
   input  wire logic                cpu_clock_halt_n,         // CPU halt pin
   input  wire logic                strap_hiz,                // Strap pin
   input  wire logic [NUM_CPU-1:0]  cpu_halt_enable,          // 1 = stoppable
   input  wire logic [NUM_CPU-1:0]  cpu_output_enable,        // Output enables
   input  wire logic [NUM_SE-1:0]   se_output_enable,         // Output enables
   input  wire logic [3:0]          spread_select,            // Spread code
   input  wire logic                wireless_mode,            // Slew mode
   input  wire logic                cfg_wr,                   // Write strobe
   input  wire logic [7:0]          cfg_wdata,                // Write data
   output      logic [7:0]          cfg_rdata,                // Read data
   output      logic [NUM_CPU-1:0]  cpu_clock_true_leg,       // CPU true legs
   output      logic [NUM_CPU-1:0]  cpu_clock_complement_leg, // CPU comp legs
   output      logic [NUM_SE-1:0]   se_clock,                 // Single-ended
   output      logic [NUM_SE-1:0]   se_clock_oe,              // SE enables
   output      logic [2:0]          usb48_drive_strength,     // USB drive
   output      logic [2:0]          se_slew_default,          // Slew default
   output      cosp_spread_t        spread_setting,           // Spread decode
   output      logic                osc_enable,               // Crystal osc
   output      logic                vco_enable,               // VCOs
   output      logic                pll_locked                // Lock reached
);

   // ------------------------------------------------------------------
   // Spread select decode
   // ------------------------------------------------------------------
   function automatic cosp_spread_t cosp_decode(input logic [3:0] code);
      cosp_spread_t s;
      s = '0;
      s.valid = 1'b1;
      case (code)
         4'h2: s.depth_x100 = 8'h32;
         4'h3: s.depth_x100 = 8'h64;
         4'h4: s.depth_x100 = 8'h96;
         4'h5: s.depth_x100 = 8'hc8;
         4'h6: s.depth_x100 = 8'h4b;
         4'h7: s.depth_x100 = 8'h7d;
         4'h8: s.depth_x100 = 8'haf;
         4'h9: begin
            s.depth_x100 = 8'h32;
            s.center     = 1'b1;
         end
         4'ha: begin
            s.depth_x100 = 8'h4b;
            s.center     = 1'b1;
         end
         default: s = '0;
      endcase
      return s;
   endfunction : cosp_decode

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic [1:0]          pin_sync;
   logic [1:0]          halt_sync;
   logic [1:0]          strap_sync;
   cosp_pwr_t           state,        next_state;
   logic [15:0]         wait_cnt,     next_wait_cnt;
   logic [1:0]          pd_cnt,       next_pd_cnt;
   logic                strap_held,   next_strap_held;
   logic                strap_taken,  next_strap_taken;
   logic                cpu_div,      next_cpu_div;
   logic                cpu_clk,      next_cpu_clk;
   logic [1:0]          se_div,       next_se_div;
   logic                se_phase,     next_se_phase;
   logic [1:0]          halt_pipe,    next_halt_pipe;
   logic [NUM_CPU-1:0]  stopped,      next_stopped;
   logic [NUM_CPU-1:0]  next_true,    next_comp;
   logic [NUM_SE-1:0]   next_se;
   logic [2:0]          drive,        next_drive;
   logic                pin_s,        halt_s;
   logic                cpu_tick,     se_tick;
   logic                cpu_rise,     cpu_clock_complement_leg_rise;
   logic                clocks_live;
   logic [NUM_SE-1:0]   se_route;
   cosp_spread_t        spread_now;

   assign pin_s       = pin_sync[1];
   assign halt_s      = halt_sync[1];
   assign clocks_live = (state == PWR_RUN) || (state == PWR_STOP_OUT);
   assign cpu_tick    = clocks_live && (cpu_div == 1'(CPU_HALF_CYCLES - 1));
   assign se_tick     = clocks_live && (se_div == 2'(SE_HALF_CYCLES - 1));
   assign cpu_rise    = cpu_tick && !cpu_clk;
   assign cpu_clock_complement_leg_rise   = cpu_tick && cpu_clk;
   assign spread_now  = cosp_decode(spread_select);                          // RULE_16
   assign se_route    = {spread_now.valid, spread_now.valid, 1'b1};          // RULE_16

   // ------------------------------------------------------------------
   // Next values
   // ------------------------------------------------------------------
   always_comb begin
      next_state       = state;
      next_wait_cnt    = wait_cnt;
      next_pd_cnt      = pd_cnt;
      next_strap_held  = strap_held;
      next_strap_taken = strap_taken || (state != PWR_WAIT_GOOD);            // Strap frozen once waking
      next_drive       = drive;
      next_cpu_div     = cpu_tick ? 1'b0 : cpu_div + 1'b1;
      next_cpu_clk     = clocks_live ? (cpu_clk ^ cpu_tick) : 1'b0;
      next_se_div      = se_tick ? 2'h0 : se_div + 2'h1;
      next_se_phase    = clocks_live ? (se_phase ^ se_tick) : 1'b0;
      next_halt_pipe   = cpu_clock_complement_leg_rise ? {halt_pipe[0], halt_s} : halt_pipe;     // RULE_11
      // Stop needs both samples low, release only the first high one
      next_stopped     = cpu_rise ? (cpu_halt_enable & {NUM_CPU{~|halt_pipe}}) : stopped; // RULE_11 RULE_14 RULE_17
      if (!strap_taken) begin
         next_strap_held = strap_sync[1];
      end
      if (cfg_wr) begin
         next_drive = cfg_wdata[DRV_MSB:DRV_LSB];                            // RULE_19
      end
      case (state)
         PWR_WAIT_GOOD: begin
            if (pin_s) begin
               next_state    = PWR_WAKE;                                     // RULE_01
               next_wait_cnt = '0;
            end
         end
         PWR_WAKE: begin
            next_wait_cnt = wait_cnt + 16'h1;
            if (wait_cnt >= 16'(LOCK_WAIT - 1)) begin
               next_state = PWR_RUN;                                         // RULE_07 RULE_09
               next_pd_cnt = '0;
            end
         end
         PWR_RUN: begin
            if (pin_s) begin
               next_pd_cnt = '0;
            end else if (cpu_rise) begin
               next_pd_cnt = pd_cnt + 2'h1;                                  // RULE_04
            end
            if (!pin_s && cpu_rise && (pd_cnt == 2'(PD_EDGES - 1))) begin
               next_state = PWR_STOP_OUT;                                    // RULE_02 RULE_04
            end
         end
         PWR_STOP_OUT: begin
            if ((se_clock == '0) && (cpu_clock_true_leg == '0)) begin
               next_state = PWR_OFF;                                         // RULE_03
            end
         end
         PWR_OFF: begin
            if (pin_s) begin
               next_state    = PWR_WAKE;                                     // RULE_02
               next_wait_cnt = '0;
            end
         end
         default: next_state = PWR_WAIT_GOOD;
      endcase
      for (int i = 0; i < NUM_CPU; i++) begin
         next_true[i] = 1'b0;
         next_comp[i] = 1'b0;
         if (state == PWR_WAKE) begin
            next_true[i] = 1'b1;                                             // RULE_08
         end else if (state == PWR_RUN && cpu_output_enable[i]) begin        // RULE_13 RULE_20
            next_true[i] = next_stopped[i] ? 1'b1 : next_cpu_clk;            // RULE_10 RULE_12
            next_comp[i] = next_stopped[i] ? 1'b0 : ~next_cpu_clk;           // RULE_12
         end
      end
      for (int j = 0; j < NUM_SE; j++) begin
         if (state == PWR_RUN && se_output_enable[j] && se_route[j]) begin   // RULE_13 RULE_20
            next_se[j] = next_se_phase;                                      // RULE_10
         end else begin
            next_se[j] = se_clock[j] && !se_tick;                            // RULE_04
         end
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_sync                 <= 2'h0;
         halt_sync                <= 2'h3;
         strap_sync               <= 2'h0;
         state                    <= PWR_WAIT_GOOD;
         wait_cnt                 <= 16'h0;
         pd_cnt                   <= 2'h0;
         strap_held               <= 1'b0;
         strap_taken              <= 1'b0;
         cpu_div                  <= 1'b0;
         cpu_clk                  <= 1'b0;
         se_div                   <= 2'h0;
         se_phase                 <= 1'b0;
         halt_pipe                <= 2'h3;
         stopped                  <= '0;
         drive                    <= DRV_RESET;
         cpu_clock_true_leg       <= '0;
         cpu_clock_complement_leg <= '0;
         se_clock                 <= '0;
      end else begin
         pin_sync                 <= {pin_sync[0], power_good_pd_n};        // RULE_02
         halt_sync                <= {halt_sync[0], cpu_clock_halt_n};
         strap_sync               <= {strap_sync[0], strap_hiz};
         state                    <= next_state;
         wait_cnt                 <= next_wait_cnt;
         pd_cnt                   <= next_pd_cnt;
         strap_held               <= next_strap_held;
         strap_taken              <= next_strap_taken;
         cpu_div                  <= next_cpu_div;
         cpu_clk                  <= next_cpu_clk;
         se_div                   <= next_se_div;
         se_phase                 <= next_se_phase;
         halt_pipe                <= next_halt_pipe;
         stopped                  <= next_stopped;
         drive                    <= next_drive;
         cpu_clock_true_leg       <= next_true;
         cpu_clock_complement_leg <= next_comp;
         se_clock                 <= next_se;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign se_clock_oe          = {NUM_SE{!(state == PWR_OFF && strap_held)}}; // RULE_06
   assign osc_enable           = (state != PWR_OFF);                          // RULE_03
   assign vco_enable           = (state != PWR_OFF) && (state != PWR_WAIT_GOOD); // RULE_03
   assign pll_locked           = clocks_live;
   assign usb48_drive_strength = drive;
   assign cfg_rdata            = cosp_drive_id_t'{drive: drive, ident: PROGRAMMED_ID}; // RULE_19
   assign se_slew_default      = wireless_mode ? SLEW_WIRELESS : SLEW_NORMAL; // RULE_18
   assign spread_setting       = spread_now;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   localparam int RESUME_MAX = 3 * CPU_HALF_CYCLES;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_PD_TWO_EDGES: assert property ( // RULE_04
      $rose(state == PWR_STOP_OUT) |-> $past(pd_cnt) == 2'h1 && !$past(pin_s))
      else $error("power down entered without two low edges");
   AST_OFF_DIFF_LOW: assert property ( // RULE_06
      state == PWR_OFF |-> cpu_clock_true_leg == '0 && cpu_clock_complement_leg == '0)
      else $error("differential legs not low while powered down");
   AST_OFF_STRAP: assert property ( // RULE_06
      state == PWR_OFF |-> se_clock == '0 && se_clock_oe == {NUM_SE{!strap_held}})
      else $error("single-ended state wrong while powered down");
   AST_OSC_AFTER_LOW: assert property ( // RULE_03
      $fell(osc_enable) |-> $past(se_clock) == '0 && $past(cpu_clock_true_leg) == '0)
      else $error("oscillator stopped before outputs were low");
   AST_WAKE_BIAS: assert property ($rose(state == PWR_WAKE) |=> cpu_clock_true_leg == '1) // RULE_08
      else $error("differential outputs not driven high after release");
   AST_WAKE_BOUND: assert property (state == PWR_WAKE |-> wait_cnt < 16'(LOCK_WAIT)) // RULE_07
      else $error("power up latency exceeded");
   AST_HALT_REST: assert property ( // RULE_12
      state == PWR_RUN && stopped[0] && cpu_output_enable[0]
      |=> cpu_clock_true_leg[0] && !cpu_clock_complement_leg[0])
      else $error("stopped pair not resting true high");
   AST_RESUME: assert property ($rose(halt_s) && state == PWR_RUN |-> ##[1:RESUME_MAX] stopped == '0) // RULE_15
      else $error("CPU outputs did not resume in time");
   AST_FREE_RUN: assert property (stopped[0] |-> cpu_halt_enable[0] || $past(cpu_halt_enable[0])) // RULE_17
      else $error("free running output was stopped");
   AST_OE_LOW: assert property ( // RULE_13 RULE_20
      !cpu_output_enable[0] && $past(!cpu_output_enable[0]) && state == PWR_RUN && $past(state) == PWR_RUN
      |-> !cpu_clock_true_leg[0] && !cpu_clock_complement_leg[0])
      else $error("disabled differential output not low");
   AST_SPREAD_NA: assert property ( // RULE_16
      !spread_now.valid ##1 !spread_now.valid ##1 se_tick |=> !se_clock[SE_V27_SPREAD])
      else $error("video pin running on unused spread code");

endmodule : cosp_clock_gate

/* testbench/cosp_pm_model.sv */
// Platform power manager model driving the shared power pin and the CPU halt pin
`timescale 1ns/100ps

module cosp_pm_model #(
   parameter int PG_LAG   = 3,  // Cycles from supply up to power good
   parameter int PD_SETTLE = 5  // Cycles from power good to request tracking
) (
   input  wire logic clock,            // System clock
   input  wire logic rst,              // Async, high
   input  wire logic supply_up,        // Supply has ramped
   input  wire logic sleep_req,        // Bench wants power down
   input  wire logic halt_req,         // Bench wants CPU halt
   output      logic power_good_pd_n,  // Shared pin
   output      logic cpu_clock_halt_n  // CPU halt pin
);
   int cnt;

   // -------------------------------------------------------------
   // Pins change on the falling edge, away from the sampling edge
   // -------------------------------------------------------------
   always_ff @(negedge clock or posedge rst) begin
      if (rst) begin
         cnt              <= 0;
         power_good_pd_n  <= 1'b0;
         cpu_clock_halt_n <= 1'b1;
      end else begin
         cpu_clock_halt_n <= !halt_req;
         if (!supply_up) begin
            cnt             <= 0;
            power_good_pd_n <= 1'b0;
         end else if (cnt < PG_LAG + PD_SETTLE) begin
            cnt <= cnt + 1;
            if (cnt == PG_LAG) begin
               power_good_pd_n <= 1'b1;
            end
         end else begin
            // Initial power down follows 500 ns after power good
            power_good_pd_n <= !sleep_req;
         end
      end
   end
endmodule : cosp_pm_model

/* testbench/tb.sv */
// Self-checking testbench of the clock output stop and power down block
`timescale 1ns/100ps

module tb;
   import cosp_pkg::*;
   localparam logic [4:0] ID = 5'h0b; // Arbitrary value
   logic         clock = 0, rst = 1, supply_up = 0, sleep_req = 0, halt_req = 0;
   logic         strap_hiz = 0, wireless_mode = 0, cfg_wr = 0;
   logic [1:0]   cpu_halt_enable = 2'h0, cpu_output_enable = 2'h3, cpu_clock_true_leg, cpu_clock_complement_leg;
   logic [2:0]   se_output_enable = 3'h7, se_clock, se_clock_oe, usb48_drive_strength, se_slew_default;
   logic [3:0]   spread_select = 4'h2;
   logic [7:0]   cfg_wdata = 8'h00, cfg_rdata;
   logic         power_good_pd_n, cpu_clock_halt_n, osc_enable, vco_enable, pll_locked;
   cosp_spread_t spread_setting;
   int           n_mismatch = 0, cmp_count = 0, cyc = 0, n;
   logic [1:0]   ct;
   logic [2:0]   st;
   // Expected {valid, center, depth} per spread code
   logic [9:0]   spr [16] = '{10'h000, 10'h000, 10'h232, 10'h264, 10'h296, 10'h2c8, 10'h24b, 10'h27d,
                              10'h2af, 10'h332, 10'h34b, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000};

   cosp_pm_model u_cosp_pm_model (.clock(clock), .rst(rst), .supply_up(supply_up), .sleep_req(sleep_req),
      .halt_req(halt_req), .power_good_pd_n(power_good_pd_n), .cpu_clock_halt_n(cpu_clock_halt_n));

   cosp_clock_gate #(.LOCK_WAIT(8), .PROGRAMMED_ID(ID)) u_cosp_clock_gate (.clock(clock), .rst(rst),
      .power_good_pd_n(power_good_pd_n), .cpu_clock_halt_n(cpu_clock_halt_n), .strap_hiz(strap_hiz),
      .cpu_halt_enable(cpu_halt_enable), .cpu_output_enable(cpu_output_enable),
      .se_output_enable(se_output_enable), .spread_select(spread_select), .wireless_mode(wireless_mode),
      .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cpu_clock_true_leg(cpu_clock_true_leg),
      .cpu_clock_complement_leg(cpu_clock_complement_leg), .se_clock(se_clock), .se_clock_oe(se_clock_oe),
      .usb48_drive_strength(usb48_drive_strength), .se_slew_default(se_slew_default),
      .spread_setting(spread_setting), .osc_enable(osc_enable), .vco_enable(vco_enable),
      .pll_locked(pll_locked));

   always #50 clock = ~clock;

   // -------------------------------------------------------------
   // Hang guard
   // -------------------------------------------------------------
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // Which outputs toggled over 8 cycles
   task automatic watch();
      logic [1:0] pc;
      logic [2:0] ps;
      ct = 2'h0;
      st = 3'h0;
      pc = cpu_clock_true_leg;
      ps = se_clock;
      repeat (8) begin
         @(negedge clock);
         ct |= pc ^ cpu_clock_true_leg;
         st |= ps ^ se_clock;
         pc = cpu_clock_true_leg;
         ps = se_clock;
      end
   endtask : watch

   task automatic do_reset(input logic strap);
      rst = 1'b1;
      strap_hiz = strap;
      supply_up = 1'b0;
      repeat (8) @(negedge clock);
      rst = 1'b0;
      supply_up = 1'b1;
   endtask : do_reset

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_power_up();
      check("drive_reset", usb48_drive_strength, 3'h5);
      check("rdata_reset", cfg_rdata, {3'h5, ID});
      check("lock_reset", pll_locked, 1'b0);
      for (n = 0; n < 40 && vco_enable !== 1'b1; n++) @(negedge clock);
      // Legs follow the wake state one cycle later
      @(negedge clock);
      check("wake_true", {pll_locked, cpu_clock_true_leg}, 3'h3);
      for (n = 0; n < 40 && pll_locked !== 1'b1; n++) @(negedge clock);
      check("locked", pll_locked, 1'b1);
      watch();
      check("cpu_run", ct, 2'h3);
      check("se_run", st, 3'h7);
   endtask : t_power_up

   task automatic t_register();
      cfg_wr = 1'b1;
      cfg_wdata = 8'h3f;
      @(negedge clock);
      check("rdata_a", cfg_rdata, {3'h1, ID});
      cfg_wdata = 8'hdf;
      @(negedge clock);
      cfg_wr = 1'b0;
      check("rdata_b", cfg_rdata, {3'h6, ID});
      check("drive_b", usb48_drive_strength, 3'h6);
      for (n = 0; n < 2; n++) begin
         wireless_mode = n[0];
         #1 check("slew", se_slew_default, n[0] ? 3'h7 : 3'h5);
      end
   endtask : t_register

   task automatic t_spread();
      for (int c = 0; c < 16; c++) begin
         spread_select = c[3:0];
         // Let the video pins settle on the new code
         repeat (4) @(negedge clock);
         watch();
         check("spread_valid", spread_setting.valid, spr[c][9]);
         if (spr[c][9]) check("spread_set", spread_setting, spr[c]);
         check("v27_run", st[2:1], spr[c][9] ? 2'h3 : 2'h0);
      end
      spread_select = 4'h2;
   endtask : t_spread

   task automatic t_halt();
      cpu_halt_enable = 2'h1;
      halt_req = 1'b1;
      repeat (14) @(negedge clock);
      watch();
      check("halt_cpu", ct, 2'h2);
      check("halt_se", st, 3'h7);
      check("halt_legs", {cpu_clock_true_leg[0], cpu_clock_complement_leg[0]}, 2'h2);
      halt_req = 1'b0;
      ct = 2'h0;
      for (n = 0; n < 10 && ct[0] !== 1'b1; n++) watch();
      check("resume", ct, 2'h3);
   endtask : t_halt

   task automatic t_disable();
      cpu_output_enable = 2'h2;
      se_output_enable = 3'h6;
      repeat (4) @(negedge clock);
      watch();
      check("dis_cpu", ct, 2'h2);
      check("dis_legs", {cpu_clock_true_leg[0], cpu_clock_complement_leg[0]}, 2'h0);
      check("dis_se", {st[0], se_clock[0]}, 2'h0);
      cpu_output_enable = 2'h3;
      se_output_enable = 3'h7;
   endtask : t_disable

   task automatic t_power_down();
      cpu_halt_enable = 2'h3;
      halt_req = 1'b1;
      sleep_req = 1'b1;
      for (n = 0; n < 30 && osc_enable !== 1'b0; n++) @(negedge clock);
      check("osc_off", osc_enable, 1'b0);
      check("pd_legs", {cpu_clock_true_leg, cpu_clock_complement_leg}, 4'h0);
      check("pd_se", {se_clock, se_clock_oe, vco_enable}, 7'h0e);
      halt_req = 1'b0;
      sleep_req = 1'b0;
      repeat (5) @(negedge clock);
      check("wake_legs", {cpu_clock_true_leg, cpu_clock_complement_leg}, 4'hc);
      for (n = 0; n < 20 && pll_locked !== 1'b1; n++) @(negedge clock);
      watch();
      check("relock", {pll_locked, ct}, 3'h7);
   endtask : t_power_down

   task automatic t_strap();
      sleep_req = 1'b1;
      do_reset(1'b1);
      for (n = 0; n < 40 && pll_locked !== 1'b1; n++) @(negedge clock);
      for (n = 0; n < 40 && osc_enable !== 1'b0; n++) @(negedge clock);
      check("strap_off", osc_enable, 1'b0);
      check("strap_hiz", {se_clock_oe, se_clock}, 6'h00);
      sleep_req = 1'b0;
   endtask : t_strap

   initial begin
      do_reset(1'b0);
      t_power_up();
      $display("test power_up done");
      t_register();
      $display("test register done");
      t_spread();
      $display("test spread done");
      t_halt();
      $display("test halt done");
      t_disable();
      $display("test disable done");
      t_power_down();
      $display("test power_down done");
      t_strap();
      $display("test strap done");
      give_verdict();
   end
endmodule : tb
